/* File: remote_io_defines.vh */
`ifndef REMOTE_IO_DEFINES_VH
`define REMOTE_IO_DEFINES_VH

// global register byte addresses
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
// offsets inside a connection window
`define CONN_CFG_IP         6'h00
`define CONN_CFG_PORT       6'h04
`define CONN_CFG_TIMEOUT    6'h08
`define CONN_ERR_CODE       6'h0C
`define CONN_IP_WORD0       6'h10
`define CONN_IP_WORD1       6'h14
`define CONN_IP_WORD2       6'h18
`define CONN_IP_WORD3       6'h1C
`define CONN_PORT_WORD      6'h20
`define CONN_STATE          6'h24

// reset values
`define CTRL_RESET          3'h0
`define CFG_IP_RESET        32'h00000000
`define CFG_PORT_RESET      16'h083E
`define CFG_TIMEOUT_RESET   8'h0A

// error status word codes
`define CODE_NORMAL         16'h0000
`define CODE_TIMEOUT        16'h0001
`define CODE_DISCONNECTED   16'h0002
`define CODE_SLAVE_FAULT    16'h000A

// cycles in one timeout step
`define TIMEOUT_STEP_MS     100
`define CLK_FREQ_KHZ        200000
`define TIMEOUT_STEP_CYCLES (`TIMEOUT_STEP_MS * `CLK_FREQ_KHZ)

// axi response codes
`define RESP_OKAY           2'h0
`define RESP_DECERR         2'h3

`endif

/* File: scan_end_pulse.v */
`timescale 1ns/100ps
`default_nettype none

module scan_end_pulse (
    input  wire aclk,
    input  wire aresetn,
    input  wire end_scan_active,
    output wire scan_pulse
);

    reg prev;

    // remember the level seen on the previous edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            prev <= 1'b0;
        end else begin
            prev <= end_scan_active;
        end
    end

    // one pulse at the entry into end-of-scan processing
    assign scan_pulse = end_scan_active & ~prev;

endmodule // scan_end_pulse

`default_nettype wire

/* File: step_timer.v */
`timescale 1ns/100ps
`default_nettype none

module step_timer #(
    parameter STEP_CYCLES = 20000000,
    parameter PRE_W       = 25
) (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       start,
    input  wire       stop,
    input  wire [7:0] limit,
    output reg        expired
);

    localparam [PRE_W-1:0] PRE_LAST = STEP_CYCLES - 1;

    reg             running;
    reg [PRE_W-1:0] pre;
    reg [7:0]       steps;

    // prescaler counts whole steps; expiry pulses once after limit steps
    always @(posedge aclk) begin
        if (!aresetn) begin
            running <= 1'b0;
            pre     <= {PRE_W{1'b0}};
            steps   <= 8'h00;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (start) begin
                running <= 1'b1;
                pre     <= {PRE_W{1'b0}};
                steps   <= (limit == 8'h00) ? 8'h01 : limit; // zero is taken as one step
            end else if (stop) begin
                running <= 1'b0;
            end else if (running) begin
                if (pre == PRE_LAST) begin
                    pre <= {PRE_W{1'b0}};
                    if (steps == 8'h01) begin
                        running <= 1'b0;
                        expired <= 1'b1;
                    end else begin
                        steps <= steps - 8'h01;
                    end
                end else begin
                    pre <= pre + {{(PRE_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // step_timer

`default_nettype wire

/* File: remote_io_link_monitor.v */
// Operation
// - per-connection connected flag, off when not connected
// - keep connected slave IP in four words
// - keep connected slave port in one word
// - error flag on while error persists
// - status codes: 0, 1 timeout, 2 disconnected, 10
// - slave fault with working exchange reports 10
// - requests launched only at end-of-scan
// - after reset: error on, status disconnected
// - failed connect keeps error and disconnected code
// - successful connect clears error, code normal
// - missing response past timeout gives code 1
// - late response clears error, code normal
// - all eligible slaves requested in same cycle
// - at most one outstanding request per connection
// - answered slaves re-requested together next scan end
// - timeout 100 ms to 25,500 ms, 100 ms steps
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "remote_io_defines.vh"

module remote_io_link_monitor #(
    parameter STEP_CYCLES = `TIMEOUT_STEP_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        end_scan_active,
    input  wire [2:0]  connect_ok,
    input  wire [2:0]  connect_fail,
    input  wire [2:0]  link_drop,
    input  wire [2:0]  response_valid,
    input  wire [2:0]  response_fault,
    output wire [2:0]  connect_req,
    output wire [2:0]  request_issue,
    output wire [95:0] target_ip,
    output wire [47:0] target_port,
    output wire        conn1_connected_flag,
    output wire        conn2_connected_flag,
    output wire        conn3_connected_flag,
    output wire [63:0] conn1_peer_ip_words,
    output wire [63:0] conn2_peer_ip_words,
    output wire [63:0] conn3_peer_ip_words,
    output wire [15:0] conn1_peer_port_word,
    output wire [15:0] conn2_peer_port_word,
    output wire [15:0] conn3_peer_port_word,
    output wire        slave1_comm_error_flag,
    output wire        slave2_comm_error_flag,
    output wire        slave3_comm_error_flag,
    output wire [15:0] slave1_error_code_word,
    output wire [15:0] slave2_error_code_word,
    output wire [15:0] slave3_error_code_word
);

    localparam [3:0] ST_IDLE       = 4'b0001;
    localparam [3:0] ST_CONNECTING = 4'b0010;
    localparam [3:0] ST_READY      = 4'b0100;
    localparam [3:0] ST_WAIT       = 4'b1000;

    // byte-lane merge of a write
    function [31:0] merge;
        input [31:0] old;
        input [31:0] val;
        input [3:0]  strb;
        integer      b;
        begin
            for (b = 0; b < 4; b = b + 1) begin
                merge[b*8 +: 8] = strb[b] ? val[b*8 +: 8] : old[b*8 +: 8];
            end
        end
    endfunction

    // octet k of an address as a data word
    function [15:0] ip_word;
        input [31:0] ip;
        input [1:0]  k;
        begin
            ip_word = {8'h00, ip[(3 - k) * 8 +: 8]};
        end
    endfunction

    reg  [2:0]  ctrl_enable;
    reg  [31:0] cfg_ip      [0:2];
    reg  [15:0] cfg_port    [0:2];
    reg  [7:0]  cfg_timeout [0:2];
    wire        scan_pulse;
    wire [2:0]  connected_all;
    wire [2:0]  err_all;
    wire [47:0] code_all;
    wire [95:0] peer_ip_all;
    wire [191:0] ipw_all;
    wire [47:0] peer_port_all;
    wire [11:0] state_all;

    // single edge shared by all connections so requests leave together
    scan_end_pulse u_scan (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .end_scan_active(end_scan_active),
        .scan_pulse     (scan_pulse)
    );

    // per-connection supervisor
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : conn
            reg  [3:0]  state;
            reg         connected;
            reg         err_flag;
            reg  [15:0] err_code;
            reg  [31:0] peer_ip;
            reg  [15:0] peer_port;
            reg         conn_req_q;
            reg         req_q;
            wire        expired;
            wire        enabled = ctrl_enable[g];
            wire        launch  = scan_pulse & enabled;
            wire        start_t = launch & ((state == ST_IDLE) | (state == ST_READY));
            wire        stop_t  = connect_ok[g] | connect_fail[g] | response_valid[g]
                                  | link_drop[g] | ~enabled;

            // response/connect timeout in 100 ms steps
            step_timer #(
                .STEP_CYCLES(STEP_CYCLES)
            ) u_timer (
                .aclk   (aclk),
                .aresetn(aresetn),
                .start  (start_t),
                .stop   (stop_t),
                .limit  (cfg_timeout[g]),
                .expired(expired)
            );

            // connection state machine, touching only its own connection
            always @(posedge aclk) begin
                if (!aresetn) begin
                    state      <= ST_IDLE;
                    connected  <= 1'b0;
                    err_flag   <= 1'b1;
                    err_code   <= `CODE_DISCONNECTED;
                    peer_ip    <= 32'h00000000;
                    peer_port  <= 16'h0000;
                    conn_req_q <= 1'b0;
                    req_q      <= 1'b0;
                end else begin
                    conn_req_q <= 1'b0;
                    req_q      <= 1'b0;
                    if (!enabled || (link_drop[g] && state != ST_IDLE)) begin
                        state     <= ST_IDLE;
                        connected <= 1'b0;
                        err_flag  <= 1'b1;
                        err_code  <= `CODE_DISCONNECTED;
                    end else begin
                        case (state)
                            ST_IDLE: begin
                                if (launch) begin
                                    state      <= ST_CONNECTING;
                                    conn_req_q <= 1'b1;
                                end
                            end
                            ST_CONNECTING: begin
                                if (connect_ok[g]) begin
                                    state     <= ST_READY;
                                    connected <= 1'b1;
                                    peer_ip   <= cfg_ip[g];
                                    peer_port <= cfg_port[g];
                                    err_flag  <= 1'b0;
                                    err_code  <= `CODE_NORMAL;
                                end else if (connect_fail[g] || expired) begin
                                    state    <= ST_IDLE;
                                    err_flag <= 1'b1;
                                    err_code <= `CODE_DISCONNECTED;
                                end
                            end
                            ST_READY: begin
                                if (launch) begin
                                    state <= ST_WAIT;
                                    req_q <= 1'b1;
                                end
                            end
                            ST_WAIT: begin
                                if (response_valid[g]) begin
                                    state <= ST_READY;
                                    if (response_fault[g]) begin
                                        err_flag <= 1'b1;
                                        err_code <= `CODE_SLAVE_FAULT;
                                    end else begin
                                        err_flag <= 1'b0;
                                        err_code <= `CODE_NORMAL;
                                    end
                                end else if (expired) begin
                                    err_flag <= 1'b1;
                                    err_code <= `CODE_TIMEOUT;
                                end
                            end
                            default: begin
                                state <= ST_IDLE;
                            end
                        endcase
                    end
                end
            end

            // gather per-connection results onto shared vectors
            assign connect_req[g]            = conn_req_q;
            assign request_issue[g]          = req_q;
            assign connected_all[g]          = connected;
            assign err_all[g]                = err_flag;
            assign code_all[g*16 +: 16]      = err_code;
            assign peer_ip_all[g*32 +: 32]   = peer_ip;
            assign ipw_all[g*64 +: 64]       = {8'h00, peer_ip[7:0], 8'h00, peer_ip[15:8],
                                               8'h00, peer_ip[23:16], 8'h00, peer_ip[31:24]};
            assign peer_port_all[g*16 +: 16] = peer_port;
            assign state_all[g*4 +: 4]       = state;
            assign target_ip[g*32 +: 32]     = cfg_ip[g];
            assign target_port[g*16 +: 16]   = cfg_port[g];
        end
    endgenerate

    // status ports, each from its connection's flip-flops
    assign conn1_connected_flag   = connected_all[0];
    assign conn2_connected_flag   = connected_all[1];
    assign conn3_connected_flag   = connected_all[2];
    assign conn1_peer_ip_words    = ipw_all[63:0];
    assign conn2_peer_ip_words    = ipw_all[127:64];
    assign conn3_peer_ip_words    = ipw_all[191:128];
    assign conn1_peer_port_word   = peer_port_all[15:0];
    assign conn2_peer_port_word   = peer_port_all[31:16];
    assign conn3_peer_port_word   = peer_port_all[47:32];
    assign slave1_comm_error_flag = err_all[0];
    assign slave2_comm_error_flag = err_all[1];
    assign slave3_comm_error_flag = err_all[2];
    assign slave1_error_code_word = code_all[15:0];
    assign slave2_error_code_word = code_all[31:16];
    assign slave3_error_code_word = code_all[47:32];

    // write channel capture: address and data may arrive in either order
    reg        aw_held;
    reg        w_held;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    wire       do_write = aw_held & w_held & ~s_axi_bvalid;
    wire [1:0] wr_sel   = aw_addr[7:6];
    wire [1:0] wr_ci    = wr_sel - 2'd1;
    wire       wr_conn  = (wr_sel != 2'd0);
    reg        wr_hit;

    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;

    // decode of writable addresses: control, or the three config words
    always @* begin
        wr_hit = wr_conn ? (aw_addr[5:0] <= `CONN_CFG_TIMEOUT && aw_addr[1:0] == 2'h0)
                         : (aw_addr == `REG_CTRL);
    end

    // write path and register file
    integer i;
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            ctrl_enable  <= `CTRL_RESET;
            for (i = 0; i < 3; i = i + 1) begin
                cfg_ip[i]      <= `CFG_IP_RESET;
                cfg_port[i]    <= `CFG_PORT_RESET;
                cfg_timeout[i] <= `CFG_TIMEOUT_RESET;
            end
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
                if (wr_hit && !wr_conn && w_strb[0]) begin
                    ctrl_enable <= w_data[2:0];
                end
                if (wr_hit && wr_conn) begin
                    case (aw_addr[5:0])
                        `CONN_CFG_IP: begin
                            cfg_ip[wr_ci] <= merge(cfg_ip[wr_ci], w_data, w_strb);
                        end
                        `CONN_CFG_PORT: begin
                            cfg_port[wr_ci] <= {w_strb[1] ? w_data[15:8] : cfg_port[wr_ci][15:8],
                                                w_strb[0] ? w_data[7:0] : cfg_port[wr_ci][7:0]};
                        end
                        default: begin
                            if (w_strb[0]) begin
                                cfg_timeout[wr_ci] <= w_data[7:0];
                            end
                        end
                    endcase
                end
            end
        end
    end

    // read decode of the register file
    wire [1:0] rd_sel  = s_axi_araddr[7:6];
    wire [1:0] rd_ci   = rd_sel - 2'd1;
    reg        rd_hit;
    reg [31:0] rd_word;
    always @* begin
        rd_hit  = 1'b1;
        rd_word = 32'h00000000;
        if (rd_sel == 2'd0) begin
            case (s_axi_araddr)
                `REG_CTRL:   rd_word = {29'h00000000, ctrl_enable};
                `REG_STATUS: rd_word = {25'h0000000, err_all, 1'b0, connected_all};
                default:     rd_hit  = 1'b0;
            endcase
        end else begin
            case (s_axi_araddr[5:0])
                `CONN_CFG_IP:      rd_word = cfg_ip[rd_ci];
                `CONN_CFG_PORT:    rd_word = {16'h0000, cfg_port[rd_ci]};
                `CONN_CFG_TIMEOUT: rd_word = {24'h000000, cfg_timeout[rd_ci]};
                `CONN_ERR_CODE:    rd_word = {16'h0000, code_all[rd_ci*16 +: 16]};
                `CONN_IP_WORD0, `CONN_IP_WORD1, `CONN_IP_WORD2, `CONN_IP_WORD3:
                    rd_word = {16'h0000, ip_word(peer_ip_all[rd_ci*32 +: 32],
                                                 s_axi_araddr[3:2])};
                `CONN_PORT_WORD:   rd_word = {16'h0000, peer_port_all[rd_ci*16 +: 16]};
                `CONN_STATE:       rd_word = {28'h0000000, state_all[rd_ci*4 +: 4]};
                default:           rd_hit  = 1'b0;
            endcase
        end
    end

    assign s_axi_arready = ~s_axi_rvalid;

    // read channel: answer one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // remote_io_link_monitor

`default_nettype wire

/* File: remote_io_link_monitor_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module remote_io_link_monitor_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        end_scan_active,
    input wire logic [2:0]  link_drop,
    input wire logic [2:0]  response_valid,
    input wire logic [2:0]  response_fault,
    input wire logic [2:0]  connect_ok,
    input wire logic [2:0]  connect_req,
    input wire logic [2:0]  request_issue,
    input wire logic [47:0] target_port,
    input wire logic        conn1_connected_flag,
    input wire logic        conn2_connected_flag,
    input wire logic [15:0] conn1_peer_port_word,
    input wire logic        slave1_comm_error_flag,
    input wire logic [15:0] slave1_error_code_word
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [1:0] busy;
    wire logic [15:0] code = slave1_error_code_word;
    wire logic        err1 = slave1_comm_error_flag;
    wire logic        up1  = conn1_connected_flag;
    // requests still unanswered on connections 1 and 2
    always @(posedge aclk) begin
        if (!aresetn) busy <= 2'h0;
        else busy <= (busy | request_issue[1:0]) & ~response_valid[1:0]
            & {conn2_connected_flag, up1};
    end
    sequence launch_s;
        !end_scan_active ##1 end_scan_active;
    endsequence
    chk_code_legal: assert property (code inside {16'h0, 16'h1, 16'h2, 16'hA})
        else $error("error code outside the set");
    chk_flag_code: assert property (err1 == (code != 16'h0))
        else $error("error flag and code disagree");
    chk_launch_only: assert property ((request_issue | connect_req) != 3'h0 |->
        $past(end_scan_active) && !$past(end_scan_active, 2)) else $error("late request");
    chk_idle_disc: assert property (!up1 |-> err1 && code == 16'h2)
        else $error("unconnected slave not disconnected");
    chk_connect_ok: assert property ($rose(up1) |-> $past(connect_ok[0]) && !err1 &&
        code == 16'h0 && conn1_peer_port_word == $past(target_port[15:0])) else $error("connect");
    chk_resp_code: assert property (busy[0] && response_valid[0] && !link_drop[0] |=>
        code == ($past(response_fault[0]) ? 16'hA : 16'h0)) else $error("response code");
    chk_one_request: assert property (busy != 2'h0 |-> (busy & request_issue[1:0]) == 2'h0)
        else $error("second request outstanding");
    chk_same_cycle: assert property (launch_s ##0 (up1 && conn2_connected_flag && !busy)
        |=> request_issue[1:0] == 2'h3) else $error("requests not together");
endmodule // remote_io_link_monitor_asserts
bind remote_io_link_monitor remote_io_link_monitor_asserts i_chk (.*);
`default_nettype wire

/* File: remote_io_slave_model.sv */
`timescale 1ns/100ps
`default_nettype none
module remote_io_slave_model (
    input  wire logic        aclk,
    input  wire logic [2:0]  connect_req,
    input  wire logic [2:0]  request_issue,
    input  wire logic [47:0] target_port,
    input  wire logic [23:0] delay,
    input  wire logic [2:0]  refuse,
    input  wire logic [2:0]  fault,
    input  wire logic [2:0]  mute,
    output var  logic [2:0]  connect_ok,
    output var  logic [2:0]  connect_fail,
    output var  logic [2:0]  response_valid,
    output var  logic [2:0]  response_fault
);
    localparam logic [15:0] LISTEN_PORT = 16'h083E;
    logic [7:0] cnt [3];
    logic [2:0] busy = 3'h0;
    logic [2:0] is_conn;
    logic [2:0] accept;
    // a slave takes a connection only on its listening port
    for (genvar g = 0; g < 3; g++) begin : g_acc
        assign accept[g] = !refuse[g] && target_port[16*g+:16] == LISTEN_PORT;
    end
    initial {connect_ok, connect_fail, response_valid, response_fault} = 12'h0;
    // each slave answers after its own delay; a muted one holds its answer
    always @(posedge aclk) begin
        {connect_ok, connect_fail, response_valid} <= 9'h0;
        response_fault <= ~response_fault;
        for (int i = 0; i < 3; i++) begin
            if (connect_req[i] || request_issue[i]) begin
                busy[i] <= 1'b1;
                is_conn[i] <= connect_req[i];
                cnt[i] <= delay[8*i+:8];
            end else if (busy[i] && cnt[i] != 8'h00) begin
                cnt[i] <= cnt[i] - 8'h01;
            end else if (busy[i] && !mute[i]) begin
                busy[i] <= 1'b0;
                connect_ok[i] <= is_conn[i] && accept[i];
                connect_fail[i] <= is_conn[i] && !accept[i];
                response_valid[i] <= !is_conn[i];
                response_fault[i] <= fault[i];
            end
        end
    end
endmodule // remote_io_slave_model
`default_nettype wire

/* File: remote_io_link_monitor_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module remote_io_link_monitor_tb_top;
    logic        aclk, aresetn, end_scan_active, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        conn1_connected_flag, conn2_connected_flag, conn3_connected_flag;
    logic        slave1_comm_error_flag, slave2_comm_error_flag, slave3_comm_error_flag;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [2:0]  connect_ok, connect_fail, link_drop, response_valid, response_fault;
    logic [2:0]  connect_req, request_issue, refuse, fault, mute;
    logic [23:0] delay;
    logic [47:0] target_port;
    logic [95:0] target_ip;
    logic [63:0] conn1_peer_ip_words, conn2_peer_ip_words, conn3_peer_ip_words;
    logic [15:0] conn1_peer_port_word, conn2_peer_port_word, conn3_peer_port_word;
    logic [15:0] slave1_error_code_word, slave2_error_code_word, slave3_error_code_word;
    int          n_compared = 0;
    int          miscompares = 0;
    // grouped views, connection 3 on the left
    wire logic [2:0]  errs = {slave3_comm_error_flag, slave2_comm_error_flag, slave1_comm_error_flag};
    wire logic [2:0]  conns = {conn3_connected_flag, conn2_connected_flag, conn1_connected_flag};
    wire logic [47:0] codes = {slave3_error_code_word, slave2_error_code_word, slave1_error_code_word};
    remote_io_link_monitor #(.STEP_CYCLES(10)) i_dut (.*);
    remote_io_slave_model i_peer (.*);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        `CHECK("rdata", s_axi_rdata, e)
        `CHECK("rresp", s_axi_rresp, er)
        s_axi_rready <= 1'b0;
    endtask
    // one end-of-scan phase plus settling room
    task automatic scan();
        end_scan_active <= 1'b1;
        repeat (3) @(posedge aclk);
        end_scan_active <= 1'b0;
        repeat (40) @(posedge aclk);
    endtask
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {aresetn, end_scan_active, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
        {s_axi_arvalid, s_axi_rready, link_drop, fault, mute} = 11'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_wstrb, refuse, delay} = {4'hF, 3'h4, 24'h020601};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHECK("errors", errs, 3'h7)
        `CHECK("codes", codes, 48'h0002_0002_0002)
        rd_chk(8'h04, 32'h0000_0070, 2'h0);
        rd_chk(8'hFC, 32'h0000_0000, 2'h3);
        $display("test reset done");
        wr(8'h40, 32'hC0A8_0A05);
        wr(8'h88, 32'h0000_0002);
        wr(8'h00, 32'h0000_0007);
        scan();
        `CHECK("conns", conns, 3'h3)
        `CHECK("codes", codes, 48'h0002_0000_0000)
        `CHECK("ip", conn1_peer_ip_words, 64'h0005_000A_00A8_00C0)
        `CHECK("port", conn1_peer_port_word, 16'h083E)
        `CHECK("tip", target_ip[31:0], 32'hC0A8_0A05)
        rd_chk(8'h50, 32'h0000_00C0, 2'h0);
        $display("test connect done");
        fault <= 3'h1;
        scan();
        `CHECK("codes", codes, 48'h0002_0000_000A)
        `CHECK("errors", errs, 3'h5)
        $display("test fault done");
        {fault, mute} <= 6'h02;
        scan();
        `CHECK("codes", codes, 48'h0002_0001_0000)
        scan();
        `CHECK("codes", codes, 48'h0002_0001_0000)
        mute <= 3'h0;
        repeat (3) @(posedge aclk);
        `CHECK("codes", codes, 48'h0002_0000_0000)
        $display("test timeout done");
        link_drop <= 3'h1;
        @(posedge aclk);
        link_drop <= 3'h0;
        repeat (2) @(posedge aclk);
        `CHECK("conns", conns, 3'h2)
        rd_chk(8'h04, 32'h0000_0052, 2'h0);
        $display("test drop done");
        wrap_up();
    end
    // cut a hung run short
    initial begin
        repeat (3000) @(posedge aclk);
        miscompares++;
        wrap_up();
    end
endmodule // remote_io_link_monitor_tb_top
`default_nettype wire
